// ---- csr_int_line.sv ----
// Host-side model of the interrupt line with its external pull-up.
`timescale 1ns/100ps
module csr_int_line (
   input wire logic int_pin_o,
   input wire logic int_pin_oe,
   output logic int_line_n
);
   // A released line floats up to the pull-up, never to the last driven value.
   assign int_line_n = int_pin_oe ? int_pin_o : 1'b1;
endmodule

// ---- csr_pkg.sv ----
// Constants for the colour sensor status and result register block.
package csr_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_AUX = 8'h90;
   localparam logic [7:0] IDX_IDENT = 8'h92;
   localparam logic [7:0] IDX_STATUS = 8'h93;
   localparam logic [7:0] IDX_CLR_LO = 8'h94;
   localparam logic [7:0] IDX_CLR_HI = 8'h95;
   localparam logic [7:0] IDX_RED_LO = 8'h96;
   localparam logic [7:0] IDX_RED_HI = 8'h97;
   localparam logic [7:0] IDX_GRN_LO = 8'h98;
   localparam logic [7:0] IDX_GRN_HI = 8'h99;
   localparam logic [7:0] IDX_BLU_LO = 8'h9A;
   localparam logic [7:0] IDX_BLU_HI = 8'h9B;
   localparam logic [7:0] IDX_IR_SEL = 8'hC0;
   localparam logic [7:0] IDX_FORCE = 8'hE4;
   localparam logic [7:0] IDX_CCLR = 8'hE6;
   localparam logic [7:0] IDX_ACLR = 8'hE7;
   // Own registers: control (enable, persistence), thresholds, interrupt mask.
   localparam logic [7:0] IDX_CTRL = 8'hA0;
   localparam logic [7:0] IDX_LOW_TH = 8'hA1;
   localparam logic [7:0] IDX_HIGH_TH = 8'hA2;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hA3;
   // Field positions.
   localparam int SAT_BIT = 7;
   localparam int THR_BIT = 4;
   localparam int VALID_BIT = 0;
   localparam int SAT_IEN_BIT = 5;
   localparam int IR_SEL_BIT = 7;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_PERS_LSB = 4;
   // Arbitrary neutral identity values and interrupt mask reset value.
   localparam logic [5:0] PART_IDENT_DEFAULT = 6'h15;
   localparam logic [1:0] VARIANT_DEFAULT = 2'h1;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h91;
endpackage

// ---- csr_regs.sv ----
// APB register block for colour sensor status, results, shadow latch and interrupts.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
// Summary of operation
// - Read-only identity: part code in bits 7:2, variant code in bits 1:0.
// - Status bit 7 set when front end reports saturation.
// - Saturation flag cleared by channel clear command or measurement disable.
// - Saturation raises interrupt only when saturation interrupt enable set.
// - Status bit 4 set on threshold hit meeting persistence, measurement enabled.
// - Status bit 0 set once a cycle completes after enabling.
// - Clear, red, green, blue results held 16-bit, low byte first.
// - Low byte read copies high byte into shadow for next read.
// - Shadowed high byte unaffected by later conversion completions.
// - IR select bit 7 routes infrared result into clear channel.
// - Any data written to command registers performs their action.
// - Writing force command raises the interrupt.
// - Writing channel clear command clears the channel interrupt.
// - Writing clear-all command clears saturation, threshold and force interrupts, but not result valid.
// - Interrupt pin open-drain: pulled low only while interrupt pending.
// - Auxiliary bit 5 enables the saturation interrupt.
// - Persistence code: 0 every cycle, 1 any, then 2,3,5..60 consecutive.
module csr_regs
   import csr_pkg::*;
#(
   parameter int RESULT_W = 16,
   parameter logic [5:0] PART_IDENT = PART_IDENT_DEFAULT,
   parameter logic [1:0] VARIANT = VARIANT_DEFAULT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_done,
   input wire logic conv_saturated,
   input wire logic [RESULT_W-1:0] clear_value,
   input wire logic [RESULT_W-1:0] red_value,
   input wire logic [RESULT_W-1:0] green_value,
   input wire logic [RESULT_W-1:0] blue_value,
   input wire logic [RESULT_W-1:0] ir_value,
   output logic light_measure_enable,
   output logic irq,
   output logic int_pin_o,
   output logic int_pin_oe
);
   // The byte lanes and the shadow latch are laid out for 16-bit results only.
   if (RESULT_W != 16) begin
      $error("csr_regs: result width must be 16");
   end

   logic [7:0] idx;
   logic acc;
   logic wr;
   logic rd;
   logic mapped;
   logic [7:0] rbyte;
   logic saturation_flag;
   logic threshold_event_flag;
   logic result_valid_flag;
   logic saturation_irq_enable;
   logic ir_select;
   logic [3:0] persistence_code;
   logic [15:0] low_threshold;
   logic [15:0] high_threshold;
   logic [7:0] irq_mask;
   logic force_flag;
   logic [15:0] res_c;
   logic [15:0] res_r;
   logic [15:0] res_g;
   logic [15:0] res_b;
   logic [7:0] shadow_hi;
   logic [5:0] out_count;
   logic [5:0] pers_need;
   logic out_of_range;
   logic threshold_hit;
   logic [7:0] status_byte;
   logic [7:0] pend;
   logic next_irq;
   logic en_d;

   assign idx = paddr[9:2];
   assign acc = psel && penable && (paddr[1:0] == 2'h0);
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;

   // Each result is latched when a conversion completes; IR mapping chooses clear source.
   always_ff @(posedge clk) begin
      if (rst) begin
         res_c <= 16'h0000;
         res_r <= 16'h0000;
         res_g <= 16'h0000;
         res_b <= 16'h0000;
      end else if (conv_done && light_measure_enable) begin
         res_c <= ir_select ? ir_value : clear_value;
         res_r <= red_value;
         res_g <= green_value;
         res_b <= blue_value;
      end
   end

   // Persistence lookup: consecutive out-of-range results needed.
   always_comb begin
      unique case (persistence_code)
         4'h0: pers_need = 6'd0;
         4'h1: pers_need = 6'd1;
         4'h2: pers_need = 6'd2;
         4'h3: pers_need = 6'd3;
         default: pers_need = 6'(5 * (32'(persistence_code) - 32'd3));
      endcase
   end

   assign out_of_range = (clear_value < low_threshold) || (clear_value > high_threshold);
   assign threshold_hit = conv_done && light_measure_enable &&
      ((pers_need == 6'd0) ||
       (out_of_range && ({1'b0, out_count} + 7'd1 >= {1'b0, pers_need})));

   always_ff @(posedge clk) begin
      if (rst) begin
         out_count <= 6'd0;
      end else if (!light_measure_enable) begin
         out_count <= 6'd0;
      end else if (conv_done) begin
         if (!out_of_range) begin
            out_count <= 6'd0;
         end else if (out_count != 6'd63) begin
            out_count <= out_count + 6'd1;
         end
      end
   end

   // Status flags: a hardware set in the same cycle as a clear wins.
   always_ff @(posedge clk) begin
      if (rst) begin
         saturation_flag <= 1'b0;
         threshold_event_flag <= 1'b0;
         result_valid_flag <= 1'b0;
         force_flag <= 1'b0;
      end else begin
         if (conv_done && light_measure_enable && conv_saturated) begin
            saturation_flag <= 1'b1;
         end else if (!light_measure_enable || (wr && (idx == IDX_CCLR || idx == IDX_ACLR))) begin
            saturation_flag <= 1'b0;
         end
         if (threshold_hit) begin
            threshold_event_flag <= 1'b1;
         end else if (wr && (idx == IDX_CCLR || idx == IDX_ACLR)) begin
            threshold_event_flag <= 1'b0;
         end
         if (conv_done && light_measure_enable) begin
            result_valid_flag <= 1'b1;
         end else if (!light_measure_enable) begin
            result_valid_flag <= 1'b0;
         end
         if (wr && idx == IDX_FORCE) begin
            force_flag <= 1'b1;
         end else if (wr && idx == IDX_ACLR) begin
            force_flag <= 1'b0;
         end
      end
   end

   // Writable configuration.
   always_ff @(posedge clk) begin
      if (rst) begin
         light_measure_enable <= 1'b0;
         persistence_code <= 4'h0;
         low_threshold <= 16'h0000;
         high_threshold <= 16'hFFFF;
         saturation_irq_enable <= 1'b0;
         ir_select <= 1'b0;
         irq_mask <= IRQ_MASK_RESET;
      end else if (wr && pstrb[0]) begin
         unique case (idx)
            IDX_CTRL: begin
               light_measure_enable <= pwdata[CTRL_EN_BIT];
               persistence_code <= pwdata[CTRL_PERS_LSB +: 4];
            end
            IDX_LOW_TH: low_threshold <= pwdata[15:0];
            IDX_HIGH_TH: high_threshold <= pwdata[15:0];
            IDX_AUX: saturation_irq_enable <= pwdata[SAT_IEN_BIT];
            IDX_IR_SEL: ir_select <= pwdata[IR_SEL_BIT];
            IDX_IRQ_MASK: irq_mask <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // The shadow is loaded only by a low-byte read, so later conversions cannot tear it.
   always_ff @(posedge clk) begin
      if (rst) begin
         shadow_hi <= 8'h00;
      end else if (rd) begin
         unique case (idx)
            IDX_CLR_LO: shadow_hi <= res_c[15:8];
            IDX_RED_LO: shadow_hi <= res_r[15:8];
            IDX_GRN_LO: shadow_hi <= res_g[15:8];
            IDX_BLU_LO: shadow_hi <= res_b[15:8];
            default: ;
         endcase
      end
   end

   assign status_byte = {saturation_flag, 2'b00, threshold_event_flag, 3'b000, result_valid_flag};

   always_comb begin
      mapped = 1'b1;
      rbyte = 8'h00;
      unique case (idx)
         IDX_IDENT: rbyte = {PART_IDENT, VARIANT};
         IDX_STATUS: rbyte = status_byte;
         IDX_CLR_LO: rbyte = res_c[7:0];
         IDX_RED_LO: rbyte = res_r[7:0];
         IDX_GRN_LO: rbyte = res_g[7:0];
         IDX_BLU_LO: rbyte = res_b[7:0];
         IDX_CLR_HI, IDX_RED_HI, IDX_GRN_HI, IDX_BLU_HI: rbyte = shadow_hi;
         IDX_AUX: rbyte = {2'b00, saturation_irq_enable, 5'b00000};
         IDX_IR_SEL: rbyte = {ir_select, 7'h00};
         IDX_CTRL: rbyte = {persistence_code, 3'b000, light_measure_enable};
         IDX_LOW_TH: rbyte = low_threshold[7:0];
         IDX_HIGH_TH: rbyte = high_threshold[7:0];
         IDX_IRQ_MASK: rbyte = irq_mask;
         IDX_FORCE, IDX_CCLR, IDX_ACLR: rbyte = 8'h00;
         default: mapped = 1'b0;
      endcase
   end

   // Bus answers in the first access cycle; unmapped addresses return an error.
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (!mapped || paddr[1:0] != 2'h0);
         if (psel && !penable && !pwrite) begin
            if (idx == IDX_LOW_TH) begin
               prdata <= {16'h0000, low_threshold};
            end else if (idx == IDX_HIGH_TH) begin
               prdata <= {16'h0000, high_threshold};
            end else begin
               prdata <= {24'h000000, rbyte};
            end
         end
      end
   end

   // Saturation counts only when its own enable is set; force bit always counts.
   assign pend = {saturation_flag & saturation_irq_enable, 2'b00, threshold_event_flag,
                  3'b000, result_valid_flag} & irq_mask;
   assign next_irq = (|pend) || force_flag;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
         int_pin_o <= 1'b0;
         int_pin_oe <= 1'b0;
         en_d <= 1'b0;
      end else begin
         irq <= next_irq;
         int_pin_o <= 1'b0;
         int_pin_oe <= next_irq;
         en_d <= light_measure_enable;
      end
   end

   property p_ident;
      @(posedge clk) disable iff (rst)
      (psel && !penable && !pwrite && idx == IDX_IDENT) |=> prdata[7:0] == {PART_IDENT, VARIANT};
   endproperty
   a_ident: assert property (p_ident) else $error("identity read wrong");

   property p_sat_set;
      @(posedge clk) disable iff (rst)
      (conv_done && light_measure_enable && conv_saturated) |=> saturation_flag;
   endproperty
   a_sat_set: assert property (p_sat_set) else $error("saturation not set");

   property p_sat_clr;
      @(posedge clk) disable iff (rst)
      (!light_measure_enable && !$past(light_measure_enable)) |-> !saturation_flag;
   endproperty
   a_sat_clr: assert property (p_sat_clr) else $error("saturation not cleared");

   property p_sat_gate;
      @(posedge clk) disable iff (rst)
      (!saturation_irq_enable && !force_flag && !threshold_event_flag && !result_valid_flag)
      |=> !irq;
   endproperty
   a_sat_gate: assert property (p_sat_gate) else $error("ungated saturation interrupt");

   property p_valid;
      @(posedge clk) disable iff (rst)
      (conv_done && light_measure_enable) |=> result_valid_flag;
   endproperty
   a_valid: assert property (p_valid) else $error("valid flag missing");

   property p_shadow;
      @(posedge clk) disable iff (rst)
      (rd && idx == IDX_RED_LO) |=> shadow_hi == $past(res_r[15:8]);
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow not loaded");

   property p_shadow_hold;
      @(posedge clk) disable iff (rst)
      !(rd && (idx == IDX_CLR_LO || idx == IDX_RED_LO || idx == IDX_GRN_LO || idx == IDX_BLU_LO))
      |=> $stable(shadow_hi);
   endproperty
   a_shadow_hold: assert property (p_shadow_hold) else $error("shadow changed");

   property p_force;
      @(posedge clk) disable iff (rst)
      (wr && idx == IDX_FORCE) |=> ##1 (irq && int_pin_oe);
   endproperty
   a_force: assert property (p_force) else $error("force did not interrupt");

   property p_clear_all;
      @(posedge clk) disable iff (rst)
      (wr && idx == IDX_ACLR && !threshold_hit) |=> (!force_flag && !threshold_event_flag);
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("clear all failed");

   property p_pin;
      @(posedge clk) disable iff (rst)
      int_pin_oe == irq && !int_pin_o;
   endproperty
   a_pin: assert property (p_pin) else $error("interrupt pin mismatch");

   property p_thr_set;
      @(posedge clk) disable iff (rst)
      threshold_hit |=> threshold_event_flag;
   endproperty
   a_thr_set: assert property (p_thr_set) else $error("threshold flag not set");

   property p_cclr;
      @(posedge clk) disable iff (rst)
      (wr && idx == IDX_CCLR && !threshold_hit && !(conv_done && light_measure_enable))
      |=> (!threshold_event_flag && !saturation_flag);
   endproperty
   a_cclr: assert property (p_cclr) else $error("channel clear failed");

   property p_aux;
      @(posedge clk) disable iff (rst)
      (wr && pstrb[0] && idx == IDX_AUX) |=> saturation_irq_enable == $past(pwdata[SAT_IEN_BIT]);
   endproperty
   a_aux: assert property (p_aux) else $error("saturation enable not written");

   property p_pers_zero;
      @(posedge clk) disable iff (rst)
      (conv_done && light_measure_enable && persistence_code == 4'h0) |-> threshold_hit;
   endproperty
   a_pers_zero: assert property (p_pers_zero) else $error("every-cycle persistence missed");

   property p_irq_hold;
      @(posedge clk) disable iff (rst)
      ((|pend) || force_flag) |=> irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped while pending");

   property p_irq_release;
      @(posedge clk) disable iff (rst)
      (!(|pend) && !force_flag) |=> !irq;
   endproperty
   a_irq_release: assert property (p_irq_release) else $error("interrupt held after clear");

   property p_valid_clr;
      @(posedge clk) disable iff (rst)
      (!light_measure_enable && !en_d) |-> !result_valid_flag;
   endproperty
   a_valid_clr: assert property (p_valid_clr) else $error("valid flag kept when disabled");
endmodule

// ---- test_color_sensor_status_data_regs.sv ----
// Self-checking bench for the colour sensor status and result registers.
`timescale 1ns/100ps
module test_color_sensor_status_data_regs
   import csr_pkg::*;
;
   typedef struct {logic w; logic [7:0] idx; logic [31:0] d; logic e;} csr_row_t;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, er, conv_done, conv_saturated;
   logic lme, irq, int_o, int_oe, int_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] cv, rv, gv, bv, iv;
   int miscompares, compares;
   csr_row_t rows[18];

   csr_regs dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_done(conv_done), .conv_saturated(conv_saturated),
      .clear_value(cv), .red_value(rv), .green_value(gv), .blue_value(bv), .ir_value(iv),
      .light_measure_enable(lme), .irq(irq), .int_pin_o(int_o), .int_pin_oe(int_oe));
   csr_int_line host (.int_pin_o(int_o), .int_pin_oe(int_oe), .int_line_n(int_n));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task end_of_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task chk(input string s, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", s, exp, got);
         miscompares++;
      end
   endtask

   function automatic logic [11:0] ba(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction

   // The request is held until pready is sampled high at a rising edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         end_of_test();
      end
   endtask

   task rw(input logic [7:0] i, input logic [31:0] d);
      apb(1'b1, ba(i), d);
   endtask

   task rr(input string s, input logic [7:0] i, input logic [31:0] exp, input logic [31:0] m);
      apb(1'b0, ba(i), 32'h0);
      chk(s, exp, rd & m);
   endtask

   task conv(input logic [15:0] c, input logic sat);
      @(posedge clk);
      conv_done <= 1'b1;
      cv <= c;
      iv <= ~c;
      conv_saturated <= sat;
      @(posedge clk);
      conv_done <= 1'b0;
   endtask

   task run_rows(input int lo, input int hi);
      for (int i = lo; i <= hi; i++) begin
         apb(rows[i].w, ba(rows[i].idx), rows[i].d);
         if (!rows[i].w) chk("prdata", rows[i].d, rd);
         chk("pslverr", {31'h0, rows[i].e}, {31'h0, er});
      end
   endtask

   task apply_reset();
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      conv_done = 1'b0;
      conv_saturated = 1'b0;
      cv = 16'h1234;
      rv = 16'h5678;
      gv = 16'h9ABC;
      bv = 16'hDEF0;
      iv = 16'h0000;
      miscompares = 0;
      compares = 0;
      rows = '{
         '{0, IDX_IDENT, {24'h0, PART_IDENT_DEFAULT, VARIANT_DEFAULT}, 0},
         '{0, IDX_STATUS, 32'h00, 0}, '{0, IDX_IRQ_MASK, {24'h0, IRQ_MASK_RESET}, 0},
         '{0, IDX_HIGH_TH, 32'hFFFF, 0}, '{0, 8'h00, 32'h0, 1}, '{1, IDX_CTRL, 32'h11, 0},
         '{0, IDX_STATUS, 32'h01, 0},
         '{0, IDX_CLR_LO, 32'h34, 0}, '{0, IDX_CLR_HI, 32'h12, 0},
         '{0, IDX_RED_LO, 32'h78, 0}, '{0, IDX_RED_HI, 32'h56, 0},
         '{0, IDX_GRN_LO, 32'hBC, 0}, '{0, IDX_GRN_HI, 32'h9A, 0},
         '{0, IDX_BLU_LO, 32'hF0, 0}, '{0, IDX_BLU_HI, 32'hDE, 0},
         '{0, IDX_FORCE, 32'h00, 0}, '{1, IDX_IR_SEL, 32'h80, 0},
         '{0, IDX_IR_SEL, 32'h80, 0}};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      run_rows(0, 5);
      conv(16'h1234, 1'b0);
      run_rows(6, 17);
      $display("table done");
      conv(16'h5A3C, 1'b0);
      rr("ir_lo", IDX_CLR_LO, 32'hC3, 32'hFF);
      rr("ir_hi", IDX_CLR_HI, 32'hA5, 32'hFF);
      rw(IDX_IR_SEL, 32'h00);
      conv(16'h5A3C, 1'b0);
      rr("clr_lo", IDX_CLR_LO, 32'h3C, 32'hFF);
      conv(16'h7788, 1'b0);
      rr("shadow_hi", IDX_CLR_HI, 32'h5A, 32'hFF);
      $display("shadow done");
      rw(IDX_IRQ_MASK, 32'h80);
      rw(IDX_AUX, 32'h00);
      conv(16'h7788, 1'b1);
      rr("sat", IDX_STATUS, 32'h80, 32'h80);
      chk("irq", 32'h0, {31'h0, irq});
      rw(IDX_AUX, 32'h20);
      repeat (3) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      chk("int_line_n", 32'h0, {31'h0, int_n});
      rw(IDX_CCLR, 32'h5A);
      repeat (3) @(posedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      chk("int_line_n", 32'h1, {31'h0, int_n});
      rr("sat", IDX_STATUS, 32'h00, 32'h80);
      conv(16'h7788, 1'b1);
      rw(IDX_CTRL, 32'h00);
      @(posedge clk);
      chk("enable", 32'h0, {31'h0, lme});
      rr("status", IDX_STATUS, 32'h00, 32'hFF);
      $display("saturation done");
      rw(IDX_IRQ_MASK, 32'h10);
      rw(IDX_LOW_TH, 32'h100);
      rw(IDX_CTRL, 32'h21);
      conv(16'h0050, 1'b0);
      rr("status", IDX_STATUS, 32'h01, 32'hFF);
      conv(16'h0050, 1'b0);
      rr("status", IDX_STATUS, 32'h11, 32'hFF);
      chk("irq", 32'h1, {31'h0, irq});
      rw(IDX_ACLR, 32'h00);
      repeat (3) @(posedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      rw(IDX_CTRL, 32'h01);
      rw(IDX_LOW_TH, 32'h00);
      conv(16'h0050, 1'b0);
      rr("status", IDX_STATUS, 32'h11, 32'hFF);
      rw(IDX_ACLR, 32'h00);
      rw(IDX_IRQ_MASK, 32'h00);
      $display("threshold done");
      rw(IDX_FORCE, 32'hFF);
      repeat (3) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      rw(IDX_CCLR, 32'h00);
      repeat (3) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      rw(IDX_ACLR, 32'h00);
      repeat (3) @(posedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      $display("force done");
      apb(1'b1, ba(IDX_IR_SEL) | 12'h001, 32'h80);
      chk("pslverr", 32'h1, {31'h0, er});
      rr("ir_sel", IDX_IR_SEL, 32'h00, 32'hFF);
      apply_reset();
      run_rows(0, 4);
      $display("reset done");
      end_of_test();
   end
endmodule
